// [design/frame_image_statistics_regs.sv]
// Frame statistics register block with exposure servo.
// Assumes a same-clock pixel stream and a byte register port from the serial front end.
`timescale 1ns/1ns
`include "frame_stats_params.svh"
module frame_image_statistics_regs (
    // Clock and reset
    input  wire logic                        sys_clk,
    input  wire logic                        reset_n,
    // Pixel stream from image pipeline
    input  wire frame_stats_pkg::pixel_in_t  pixel,
    // Register port
    input  wire frame_stats_pkg::reg_req_t   reg_req,
    output logic [7:0]                       reg_rdata,
    output logic                             reg_rvalid,
    // Exposure to image acquisition
    output logic [15:0]                      exposure,
    output logic                             frame_update
);

    typedef struct packed {
        logic [7:0]  quality;
        logic [15:0] exposure;
        logic [7:0]  brightest;
        logic [7:0]  total;
        logic [7:0]  darkest;
        logic [7:0]  low_shadow;
        logic        shadow_armed;
        logic [7:0]  rdata;
        logic        rvalid;
        logic        update;
    } regs_state_t;

    regs_state_t                   state;
    regs_state_t                   next_state;
    logic                          frame_done;
    frame_stats_pkg::frame_stats_t frame_result;

    pixel_stats_accum u_accum (
        .sys_clk      (sys_clk),
        .reset_n      (reset_n),
        .pixel        (pixel),
        .frame_done   (frame_done),
        .frame_result (frame_result)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Exposure servo

    function automatic logic [15:0] servo(input logic [15:0] cur,
                                          input logic [7:0]  bright,
                                          input logic [7:0]  total);
        logic [15:0] step;
        logic [16:0] up;
        step  = (cur >> `EXPOSURE_STEP_SHIFT) + 16'h0001;
        up    = {1'b0, cur} + {1'b0, step};
        servo = cur;
        if (bright > `BRIGHT_HIGH || total > `TOTAL_HIGH) begin
            servo = (cur < `EXPOSURE_MIN + step) ? `EXPOSURE_MIN : cur - step;
        end else if (bright < `BRIGHT_LOW && total < `TOTAL_LOW) begin
            servo = (up > {1'b0, `EXPOSURE_MAX}) ? `EXPOSURE_MAX : up[15:0];
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        logic [7:0] total_code;
        total_code = frame_result.sum[16:`SUM_SHIFT];
        next_state        = state;
        next_state.rvalid = 1'b0;
        next_state.update = 1'b0;
        if (frame_done) begin
            // Whole set refreshes in one edge
            next_state.quality   = frame_result.features[8:1];
            next_state.brightest = frame_result.brightest;
            next_state.darkest   = frame_result.darkest;
            next_state.total     = total_code;
            next_state.exposure  = servo(state.exposure, frame_result.brightest,
                                         total_code);
            next_state.update    = 1'b1;
        end
        // Writes change no register and only end the pairing: every register here is read-only
        if (reg_req.rd) begin
            next_state.rvalid = 1'b1;
            case (reg_req.addr)
                `ADDR_SURFACE_FEATURE_QUALITY: next_state.rdata = state.quality;
                `ADDR_EXPOSURE_HIGH_BYTE: begin
                    next_state.rdata        = state.exposure[15:8];
                    next_state.low_shadow   = state.exposure[7:0];
                    next_state.shadow_armed = 1'b1;
                end
                `ADDR_EXPOSURE_LOW_BYTE: begin
                    next_state.rdata = state.shadow_armed ? state.low_shadow
                                                          : state.exposure[7:0];
                end
                `ADDR_BRIGHTEST_PIXEL:         next_state.rdata = state.brightest;
                `ADDR_INTENSITY_TOTAL_HIGH:    next_state.rdata = state.total;
                `ADDR_DARKEST_PIXEL:           next_state.rdata = state.darkest;
                default:                       next_state.rdata = `UNMAPPED_READ;
            endcase
            // Any read other than the upper byte ends the pairing
            if (reg_req.addr != `ADDR_EXPOSURE_HIGH_BYTE) begin
                next_state.shadow_armed = 1'b0;
            end
        end else if (reg_req.wr) begin
            next_state.shadow_armed = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state              <= '0;
            state.quality      <= `RST_SURFACE_FEATURE_QUALITY;
            state.exposure     <= `RST_EXPOSURE;
            state.brightest    <= `RST_BRIGHTEST_PIXEL;
            state.total        <= `RST_INTENSITY_TOTAL_HIGH;
            state.darkest      <= `RST_DARKEST_PIXEL;
        end else begin
            state <= next_state;
        end
    end

    assign reg_rdata    = state.rdata;
    assign reg_rvalid   = state.rvalid;
    assign exposure     = state.exposure;
    assign frame_update = state.update;

endmodule

// [design/frame_stats_params.svh]
// Constants for the per-frame image statistics register block.
// Assumes a pixel stream of one frame of 22 x 22 pixels per frame period.
// Overview of operation
// - Each frame the block counts the valid surface features it sees and publishes the count.
// - The feature-quality register holds the upper eight bits of a nine-bit feature count.
// - The feature-quality register never reads above 162.
// - Exposure is a 16-bit count of clock cycles, upper byte at 0x06 and lower byte at 0x07.
// - Exposure is adjusted each frame to keep average and brightest pixel in range.
// - The brightest-pixel register shows the highest pixel of each frame, updated every frame.
// - The brightest-pixel register lies between 0 and 254.
// - All pixels of a frame sum into 17 bits and the top eight bits are published.
// - The intensity-total register is the frame sum divided by 512, truncated.
// - The intensity-total register ranges 0 to 240 and may change every frame.
// - The darkest-pixel register shows the lowest pixel of each frame, within 0 to 254.
`ifndef FRAME_STATS_PARAMS_SVH
`define FRAME_STATS_PARAMS_SVH

// Register offsets
`define ADDR_SURFACE_FEATURE_QUALITY 7'h05
`define ADDR_EXPOSURE_HIGH_BYTE      7'h06
`define ADDR_EXPOSURE_LOW_BYTE       7'h07
`define ADDR_BRIGHTEST_PIXEL         7'h08
`define ADDR_INTENSITY_TOTAL_HIGH    7'h09
`define ADDR_DARKEST_PIXEL           7'h0A

// Reset values
`define RST_SURFACE_FEATURE_QUALITY  8'h00
`define RST_EXPOSURE                 16'h0064
`define RST_BRIGHTEST_PIXEL          8'hD0
`define RST_INTENSITY_TOTAL_HIGH     8'h80
`define RST_DARKEST_PIXEL            8'h00
`define UNMAPPED_READ                8'h00

// Pixel and feature limits
`define PIXEL_CEILING                8'hFE
`define FEATURE_THRESHOLD            8'h10
`define FEATURE_COUNT_CAP            9'h145
`define SUM_SHIFT                    9

// Exposure servo
`define EXPOSURE_MIN                 16'h0010
`define EXPOSURE_MAX                 16'hFF00
`define BRIGHT_HIGH                  8'hF0
`define BRIGHT_LOW                   8'h80
`define TOTAL_HIGH                   8'hB4
`define TOTAL_LOW                    8'h3C
`define EXPOSURE_STEP_SHIFT          4

`endif

// [design/frame_stats_pkg.sv]
// Types shared by the frame statistics accumulator and register block.
// Assumes the params header supplies all numeric constants.
package frame_stats_pkg;

    typedef struct packed {
        logic       valid;
        logic       first;
        logic       last;
        logic [7:0] data;
    } pixel_in_t;

    typedef struct packed {
        logic [8:0]  features;
        logic [7:0]  brightest;
        logic [7:0]  darkest;
        logic [16:0] sum;
    } frame_stats_t;

    typedef struct packed {
        logic [6:0] addr;
        logic       rd;
        logic       wr;
        logic [7:0] wdata;
    } reg_req_t;

endpackage

// [design/pixel_stats_accum.sv]
// Per-frame pixel accumulator: brightest, darkest, sum and feature count.
// Assumes a same-clock pixel stream with first and last marks on each frame.
`timescale 1ns/1ns
`include "frame_stats_params.svh"
module pixel_stats_accum (
    // Clock and reset
    input  wire logic                         sys_clk,
    input  wire logic                         reset_n,
    // Pixel stream
    input  wire frame_stats_pkg::pixel_in_t   pixel,
    // Finished frame
    output logic                              frame_done,
    output frame_stats_pkg::frame_stats_t     frame_result
);

    typedef struct packed {
        logic [7:0]                    prev;
        frame_stats_pkg::frame_stats_t acc;
        frame_stats_pkg::frame_stats_t result;
        logic                          done;
    } accum_state_t;

    accum_state_t state;
    accum_state_t next_state;

    function automatic logic [7:0] abs_diff(input logic [7:0] a, input logic [7:0] b);
        abs_diff = (a > b) ? a - b : b - a;
    endfunction

    always_comb begin
        logic [7:0]  pix;
        logic [8:0]  feat;
        logic [7:0]  hi;
        logic [7:0]  lo;
        logic [16:0] sum;
        logic        edge_hit;
        pix      = 8'h00;
        feat     = 9'h000;
        hi       = 8'h00;
        lo       = 8'h00;
        sum      = 17'h0_0000;
        edge_hit = 1'b0;
        next_state      = state;
        next_state.done = 1'b0;
        if (pixel.valid) begin
            // Clamp keeps both extremes in 0..254
            pix = (pixel.data > `PIXEL_CEILING) ? `PIXEL_CEILING : pixel.data;
            edge_hit = !pixel.first && (abs_diff(pix, state.prev) > `FEATURE_THRESHOLD);
            if (pixel.first) begin
                feat = 9'h000;
                hi   = pix;
                lo   = pix;
                sum  = {9'h000, pix};
            end else begin
                feat = state.acc.features;
                if (edge_hit && feat < `FEATURE_COUNT_CAP) begin
                    feat = feat + 9'h001;
                end
                hi  = (pix > state.acc.brightest) ? pix : state.acc.brightest;
                lo  = (pix < state.acc.darkest) ? pix : state.acc.darkest;
                sum = state.acc.sum + {9'h000, pix};
            end
            next_state.prev          = pix;
            next_state.acc.features  = feat;
            next_state.acc.brightest = hi;
            next_state.acc.darkest   = lo;
            next_state.acc.sum       = sum;
            if (pixel.last) begin
                next_state.result.features  = feat;
                next_state.result.brightest = hi;
                next_state.result.darkest   = lo;
                next_state.result.sum       = sum;
                next_state.done             = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign frame_done   = state.done;
    assign frame_result = state.result;

endmodule

// [test/frame_stats_sva.sv]
// Port checker for the frame statistics register block.
// Assumes the design's ports as declared; attached by bind.
`timescale 1ns/1ns
module frame_stats_sva (
    // Clock and reset
    input wire logic                       sys_clk,
    input wire logic                       reset_n,
    // Watched ports
    input wire frame_stats_pkg::pixel_in_t pixel,
    input wire frame_stats_pkg::reg_req_t  reg_req,
    input wire logic [7:0]                 reg_rdata,
    input wire logic                       reg_rvalid,
    input wire logic [15:0]                exposure,
    input wire logic                       frame_update
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    logic       last_px;
    logic [7:0] exp_lo;
    assign last_px = pixel.valid && pixel.last;
    assign exp_lo = exposure[7:0];
    sequence frame_end; last_px; endsequence
    sequence stats_out; ##2 frame_update; endsequence
    sequence pair_reads;
        (reg_req.rd && reg_req.addr == 7'h06) ##1 (reg_req.rd && reg_req.addr == 7'h07);
    endsequence
    a_read_answer: assert property (reg_req.rd |=> reg_rvalid)
        else $error("no answer to read");
    a_answer_cause: assert property (reg_rvalid |-> $past(reg_req.rd))
        else $error("answer without read");
    a_data_holds: assert property (!reg_rvalid |-> $stable(reg_rdata))
        else $error("read data moved");
    a_frame_update: assert property (frame_end |-> stats_out)
        else $error("no update after frame");
    a_update_cause: assert property (frame_update |-> $past(last_px, 2))
        else $error("update without frame end");
    a_exposure_steady: assert property (!frame_update |-> $stable(exposure))
        else $error("exposure moved mid frame");
    a_quality_cap: assert property (reg_rvalid && $past(reg_req.addr) == 7'h05
        |-> reg_rdata <= 8'hA2) else $error("quality too large");
    a_peak_cap: assert property (reg_rvalid && ($past(reg_req.addr) == 7'h08
        || $past(reg_req.addr) == 7'h0A) |-> reg_rdata <= 8'hFE) else $error("pixel too large");
    a_total_cap: assert property (reg_rvalid && $past(reg_req.addr) == 7'h09
        |-> reg_rdata <= 8'hF1) else $error("total too large");
    a_pair_capture: assert property (pair_reads |=> reg_rdata == $past(exp_lo, 2))
        else $error("low byte not captured");
endmodule
bind frame_image_statistics_regs frame_stats_sva i_sva (.sys_clk(sys_clk), .reset_n(reset_n),
    .pixel(pixel), .reg_req(reg_req), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .exposure(exposure), .frame_update(frame_update));

// [test/serial_host_model.sv]
// Controller model that reads the statistics registers.
// Assumes a one-cycle read answer on the register port.
`timescale 1ns/1ns
module serial_host_model (
    // Clock
    input  wire logic                 sys_clk,
    // Register port
    output frame_stats_pkg::reg_req_t reg_req,
    input  wire logic [7:0]           reg_rdata,
    input  wire logic                 reg_rvalid
);
    initial reg_req = '0;
    task automatic rd(input logic [6:0] a, output logic [7:0] d);
        @(negedge sys_clk);
        reg_req.addr = a;
        reg_req.rd = 1'b1;
        @(negedge sys_clk);
        reg_req.rd = 1'b0;
        d = reg_rvalid === 1'b1 ? reg_rdata : 8'hxx;
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] w);
        @(negedge sys_clk);
        reg_req.addr = a;
        reg_req.wdata = w;
        reg_req.wr = 1'b1;
        @(negedge sys_clk);
        reg_req.wr = 1'b0;
    endtask
    // Upper byte then lower byte, back to back
    task automatic exp_pair(output logic [15:0] x);
        @(negedge sys_clk);
        reg_req.addr = 7'h06;
        reg_req.rd = 1'b1;
        @(negedge sys_clk);
        x[15:8] = reg_rvalid === 1'b1 ? reg_rdata : 8'hxx;
        reg_req.addr = 7'h07;
        @(negedge sys_clk);
        reg_req.rd = 1'b0;
        x[7:0] = reg_rvalid === 1'b1 ? reg_rdata : 8'hxx;
    endtask
    // Average pixel from the intensity total over the 484 pixels of a frame
    task automatic avg_pixel(output logic [7:0] a);
        logic [7:0] t;
        rd(7'h09, t);
        a = 8'(int'(t) * 512 / 484);
    endtask
endmodule

// [test/tb_frame_image_statistics_regs.sv]
// Testbench for the frame statistics register block.
// Assumes the host model for register access; pixels driven here.
`timescale 1ns/1ns
module tb_frame_image_statistics_regs;
    logic                       sys_clk;
    logic                       reset_n;
    frame_stats_pkg::pixel_in_t pixel;
    frame_stats_pkg::reg_req_t  reg_req;
    logic [7:0]                 reg_rdata;
    logic                       reg_rvalid;
    logic [15:0]                exposure;
    logic                       frame_update;
    int                         mismatches;
    int                         num_checks;
    int                         cycles;
    int                         sum;
    logic [7:0]                 d;
    logic [7:0]                 e_max;
    logic [7:0]                 e_min;
    logic [8:0]                 e_feat;
    logic [15:0]                exp_e;
    logic [15:0]                x;
    logic [7:0]                 rv [6] = '{8'h00, 8'h00, 8'h64, 8'hD0, 8'h80, 8'h00};
    frame_image_statistics_regs i_dut (.sys_clk(sys_clk), .reset_n(reset_n), .pixel(pixel),
        .reg_req(reg_req), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .exposure(exposure), .frame_update(frame_update));
    serial_host_model i_host (.sys_clk(sys_clk), .reg_req(reg_req), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid));
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            summarize();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////////////
    task automatic summarize();
        if (mismatches == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic cmp(input string what, input logic [15:0] e, input logic [15:0] s);
        num_checks++;
        if (s !== e) begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, e, s);
        end
    endtask
    task automatic chk_reg(input logic [6:0] a, input logic [7:0] e);
        i_host.rd(a, d);
        cmp($sformatf("reg %h", a), {8'h00, e}, {8'h00, d});
    endtask
    function automatic logic [15:0] servo(input int v, input int b, input int t);
        int s = v / 16 + 1;
        if (b > 240 || t > 180) return 16'(v - s < 16 ? 16 : v - s);
        if (b < 128 && t < 60) return 16'(v + s > 65280 ? 65280 : v + s);
        return 16'(v);
    endfunction
    // Kind 0 flat, 1 alternating extremes, 2 over-range, 3 dark
    task automatic send_frame(input int kind);
        logic [7:0] r;
        logic [7:0] v;
        logic [7:0] p;
        int n;
        {e_max, e_min, sum, e_feat, p} = {8'h00, 8'hFF, 32'h0, 9'h000, 8'h00};
        for (int i = 0; i < 484; i++) begin
            r = kind == 0 ? 8'h64 : kind == 1 ? (i[0] ? 8'hFE : 8'h00) : kind == 2 ? 8'hFF : 8'h10;
            v = r > 8'hFE ? 8'hFE : r;
            @(negedge sys_clk);
            pixel = '{1'b1, i == 0, i == 483, r};
            e_max = v > e_max ? v : e_max;
            e_min = v < e_min ? v : e_min;
            sum += v;
            if (i > 0 && (v > p ? v - p : p - v) > 8'h10 && e_feat < 9'h145) e_feat++;
            p = v;
        end
        @(negedge sys_clk);
        pixel = '0;
        n = 0;
        while (frame_update !== 1'b1 && n < 8) begin
            @(negedge sys_clk);
            n++;
        end
        cmp("frame_update", 16'h0001, {15'h0000, frame_update});
    endtask
    task automatic check_stats();
        chk_reg(7'h05, e_feat[8:1]);
        chk_reg(7'h08, e_max);
        chk_reg(7'h09, 8'(sum >> 9));
        chk_reg(7'h0A, e_min);
        exp_e = servo(exp_e, e_max, 8'(sum >> 9));
        cmp("exposure", exp_e, exposure);
        i_host.exp_pair(x);
        cmp("exposure pair", exp_e, x);
        i_host.avg_pixel(d);
        cmp("average pixel", 16'((sum >> 9) * 512 / 484), {8'h00, d});
    endtask
    initial begin
        {pixel, reset_n, mismatches, num_checks, cycles} = '0;
        exp_e = 16'h0064;
        repeat (6) @(negedge sys_clk);
        reset_n = 1'b1;
        for (int k = 0; k < 6; k++) chk_reg(7'(5 + k), rv[k]);
        i_host.wr(7'h05, 8'hAA);
        chk_reg(7'h05, 8'h00);
        chk_reg(7'h30, 8'h00);
        chk_reg(7'h06, 8'h00);
        send_frame(1);
        chk_reg(7'h07, 8'h64);
        check_stats();
        send_frame(0);
        check_stats();
        // A write between the two exposure reads drops the captured low byte
        chk_reg(7'h06, 8'h00);
        i_host.wr(7'h06, 8'h55);
        send_frame(2);
        chk_reg(7'h07, 8'h57);
        check_stats();
        send_frame(3);
        check_stats();
        // Reset in mid run restores every register
        reset_n = 1'b0;
        repeat (2) @(negedge sys_clk);
        reset_n = 1'b1;
        for (int k = 0; k < 6; k++) chk_reg(7'(5 + k), rv[k]);
        summarize();
    end
endmodule
